// File: hdl/pmx_cfg.svh
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMX_CTRL_OFF    12'h000
`define PMX_AUXFRQ_OFF  12'h004
`define PMX_AUXCFG_OFF  12'h008
`define PMX_TIMERS_OFF  12'h00c
`define PMX_STATUS_OFF  12'h010
`define PMX_RUNT_OFF    12'h014
`define PMX_RELAY_OFF   12'h028
`define PMX_ADDR_STEP   12'h004
// ----------------------------------------------------------------
// field positions, reset values and mode codes
// ----------------------------------------------------------------
`define PMX_LOOPMODE_LSB 8
`define PMX_MAINEN_BIT   16
`define PMX_HI_LSB       16
`define PMX_CTRL_RST     32'h0001_0000
`define PMX_PM_OFF       8'h00
`define PMX_PM_FIX1      8'h01
`define PMX_PM_FLT2      8'h02
`define PMX_PM_FLT3      8'h03
`define PMX_PM_FIX11     8'h0b
`define PMX_PM_FLT12     8'h0c
`define PMX_PM_FLT13     8'h0d
`define PMX_PM_LNK52     8'h34
`define PMX_PM_LNK54     8'h36
`define PMX_RELAY_MAX    20'd1000000
`define PMX_SAVE_MASK    20'hffff0
`define PMX_WIN_MULT     8'd10
// ----------------------------------------------------------------
// timing: 100 MHz clock, hour and tenth-second bases
// ----------------------------------------------------------------
`define PMX_CLK_NS       10
`define PMX_HOUR_S       64'd3600
`define PMX_HOUR_CYC     (`PMX_HOUR_S * 64'd1000000000 / `PMX_CLK_NS)
`define PMX_TENTH_NS     64'd100000000
`define PMX_TENTH_CYC    (`PMX_TENTH_NS / `PMX_CLK_NS)
`endif

// File: hdl/pmx_pkg.sv
package pmx_pkg;
   // external loop decode result
   typedef struct packed {
      logic en;      // loop may run
      logic inv;     // inverse action
      logic run_ilk; // needs inverter running
      logic cmd_ilk; // needs loop-on input
   } pmx_loop_t;
   // aux drive state
   typedef enum logic [1:0] {
      PMX_AUX_OFF = 2'b01,
      PMX_AUX_ON  = 2'b10
   } pmx_aux_t;
endpackage : pmx_pkg

// File: hdl/pmx_cnt_if.sv
`timescale 1ns/1ps
interface pmx_cnt_if #(parameter int W = 16);
   logic         run;    // count enable level
   logic         ld;     // load strobe
   logic [W-1:0] ld_val; // load value
   logic         clr;    // clear strobe
   logic         snap;   // round down to save granularity
   logic [W-1:0] val;    // current count
   modport ctl (output run, ld, ld_val, clr, snap, input val);
   modport cnt (input run, ld, ld_val, clr, snap, output val);
endinterface : pmx_cnt_if

// File: hdl/pmx_counter.sv
`timescale 1ns/1ps
`include "pmx_cfg.svh"
module pmx_counter #(
   parameter int          W   = 16,  // counter width
   parameter bit          SAT = 0,   // saturate instead of wrap
   parameter logic [W-1:0] MAX = '1, // saturation value
   parameter longint      PRE = 1    // run cycles per count
) (
   input wire logic pclk,    // clock
   input wire logic presetn, // async reset, low
   pmx_cnt_if.cnt   p        // counter port
);
   localparam int PW = (PRE > 1) ? $clog2(PRE) : 1;
   logic [PW-1:0] pre;
   logic          step;
   // prescale: one count per PRE cycles of run
   assign step = p.run && (PRE <= 1 || pre == PW'(PRE - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre <= '0;
      end else if (p.run) begin
         pre <= step ? '0 : pre + 1'b1;
      end
   end
   // loads beat clears beat counting; the operator write always lands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p.val <= '0;
      end else if (p.ld) begin
         p.val <= p.ld_val;
      end else if (p.clr) begin
         p.val <= '0;
      end else if (p.snap) begin
         p.val <= p.val & W'(`PMX_SAVE_MASK);
      end else if (step && !(SAT && p.val >= MAX)) begin
         p.val <= p.val + 1'b1;
      end
   end
endmodule : pmx_counter

// File: hdl/pmx_top.sv
`timescale 1ns/1ps
`include "pmx_cfg.svh"
module pmx_top
   import pmx_pkg::*;
#(
   parameter longint HOUR_CYC  = `PMX_HOUR_CYC,  // cycles per hour
   parameter longint TENTH_CYC = `PMX_TENTH_CYC, // cycles per 0.1 s
   parameter int     FW        = 12,             // freq width, 0.1 Hz
   parameter int     RW        = 20              // relay count width
) (
   input  wire logic        pclk,             // apb clock
   input  wire logic        presetn,          // async reset, low
   input  wire logic        psel,             // apb select
   input  wire logic        penable,          // apb enable
   input  wire logic        pwrite,           // apb direction
   input  wire logic [11:0] paddr,            // apb byte address
   input  wire logic [31:0] pwdata,           // apb write data
   output logic      [31:0] prdata,           // apb read data
   output logic             pready,           // apb ready
   output logic             pslverr,          // apb error
   input  wire logic [FW-1:0] out_freq,       // output freq, 0.1 Hz
   input  wire logic [FW-1:0] pressure_pv,    // process value
   input  wire logic        all_motors_run,   // all set motors on
   input  wire logic        add_motor_req,    // motor add start pulse
   input  wire logic        motors_decreasing,// motor removal active
   input  wire logic        gate_on,          // output gate on
   input  wire logic        dew_prevent,      // dew prevention active
   input  wire logic [3:0]  mains_run,        // motor mains outputs
   input  wire logic [2:0]  inv_drive,        // motor inverter outputs
   input  wire logic [2:0]  slave_run,        // linked slave running
   input  wire logic [7:0]  relay_out,        // relay and y outputs
   input  wire logic        power_down,       // power-off save pulse
   input  wire logic        inv_running,      // inverter running out
   input  wire logic        ext_loop1_on_cmd, // loop-on digital input
   input  wire logic        run_cmd,          // run command
   input  wire logic        decelerating,     // decelerating
   input  wire logic signed [15:0] loop_err,  // loop error in
   output logic             aux_motor_drive,  // aux motor drive
   output logic             ext_loop_run,     // ext loop running
   output logic             ext_loop_inverse, // inverse action
   output logic             integral_hold,    // hold integral term
   output logic signed [15:0] loop_err_out    // signed loop error
);
   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl, auxfrq, auxcfg, timers;
   logic [7:0]  pump_mode_select;
   logic [7:0]  ext_loop1_mode_select;
   logic        main_loop_en;
   logic [FW-1:0] aux_motor_on_level, aux_motor_hysteresis_width;
   logic [FW-1:0] freq_detect_hysteresis, aux_motor_pressure_level;
   logic [15:0] contactor_restart_time, aux_motor_connect_timer;
   assign pump_mode_select      = ctrl[7:0];
   assign ext_loop1_mode_select = ctrl[`PMX_LOOPMODE_LSB +: 8];
   assign main_loop_en          = ctrl[`PMX_MAINEN_BIT];
   assign aux_motor_on_level         = auxfrq[FW-1:0];
   assign aux_motor_hysteresis_width = auxfrq[`PMX_HI_LSB +: FW];
   assign freq_detect_hysteresis     = auxcfg[FW-1:0];
   assign aux_motor_pressure_level   = auxcfg[`PMX_HI_LSB +: FW];
   assign contactor_restart_time     = timers[15:0];
   assign aux_motor_connect_timer    = timers[`PMX_HI_LSB +: 16];

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function automatic logic is_floating(input logic [7:0] m);
      is_floating = (m == `PMX_PM_FLT2) || (m == `PMX_PM_FLT12);
   endfunction : is_floating

   function automatic logic is_cascade(input logic [7:0] m);
      is_cascade = (m == `PMX_PM_FIX1) || (m == `PMX_PM_FLT2) ||
                   (m == `PMX_PM_FLT3) || (m == `PMX_PM_FIX11) ||
                   (m == `PMX_PM_FLT12) || (m == `PMX_PM_FLT13);
   endfunction : is_cascade

   function automatic logic [RW-1:0] max3(input logic [RW-1:0] a,
                                          input logic [RW-1:0] b,
                                          input logic [RW-1:0] c);
      logic [RW-1:0] m;
      m = (a > b) ? a : b;
      max3 = (m > c) ? m : c;
   endfunction : max3

   // loop mode table: unknown codes behave as disabled
   function automatic pmx_loop_t loop_decode(input logic [7:0] m);
      loop_decode = '0;
      case (m)
         8'h01: loop_decode = 4'b1000;
         8'h02: loop_decode = 4'b1100;
         8'h0b: loop_decode = 4'b1010;
         8'h0c: loop_decode = 4'b1110;
         8'h15: loop_decode = 4'b1001;
         8'h16: loop_decode = 4'b1101;
         8'h1f: loop_decode = 4'b1011;
         8'h20: loop_decode = 4'b1111;
         default: loop_decode = '0;
      endcase
   endfunction : loop_decode

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic        acc, wr_en, hit_ctrl, hit_auxfrq, hit_auxcfg;
   logic        hit_timers, hit_status, hit_runt, hit_relay;
   logic [11:0] runt_rel, relay_rel;
   logic [2:0]  runt_idx;
   logic [1:0]  relay_idx;
   // access phase, answered after one wait cycle
   assign acc        = psel && penable && !pready;
   assign wr_en      = acc && pwrite;
   assign runt_rel   = paddr - `PMX_RUNT_OFF;
   assign relay_rel  = paddr - `PMX_RELAY_OFF;
   assign runt_idx   = runt_rel[4:2];
   assign relay_idx  = relay_rel[3:2];
   assign hit_ctrl   = paddr == `PMX_CTRL_OFF;
   assign hit_auxfrq = paddr == `PMX_AUXFRQ_OFF;
   assign hit_auxcfg = paddr == `PMX_AUXCFG_OFF;
   assign hit_timers = paddr == `PMX_TIMERS_OFF;
   assign hit_status = paddr == `PMX_STATUS_OFF;
   assign hit_runt   = paddr >= `PMX_RUNT_OFF && paddr < `PMX_RELAY_OFF
                       && paddr[1:0] == 2'b00;
   assign hit_relay  = paddr >= `PMX_RELAY_OFF &&
                       paddr < `PMX_RELAY_OFF + 4 * `PMX_ADDR_STEP &&
                       paddr[1:0] == 2'b00;

   // configuration writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= `PMX_CTRL_RST;
         auxfrq <= '0;
         auxcfg <= '0;
         timers <= '0;
      end else if (wr_en) begin
         if (hit_ctrl)   ctrl   <= pwdata;
         if (hit_auxfrq) auxfrq <= pwdata;
         if (hit_auxcfg) auxcfg <= pwdata;
         if (hit_timers) timers <= pwdata;
      end
   end

   // ----------------------------------------------------------------
   // free-run window after a motor add
   // ----------------------------------------------------------------
   localparam int TW = (TENTH_CYC > 1) ? $clog2(TENTH_CYC) : 1;
   logic [TW-1:0] tenth_cnt;
   logic [19:0]   win_left;
   logic [15:0]   win_base;
   logic          tenth_tick, win_act;
   assign tenth_tick = tenth_cnt == TW'(TENTH_CYC - 1);
   assign win_act    = win_left != '0;
   // window length is ten times the larger timer, in 0.1 s units
   assign win_base   = (contactor_restart_time > aux_motor_connect_timer)
                       ? contactor_restart_time : aux_motor_connect_timer;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tenth_cnt <= '0;
         win_left  <= '0;
      end else begin
         tenth_cnt <= tenth_tick ? '0 : tenth_cnt + 1'b1;
         if (add_motor_req && is_floating(pump_mode_select)) begin
            win_left <= 20'(win_base) * 20'(`PMX_WIN_MULT);
         end else if (tenth_tick && win_act) begin
            win_left <= win_left - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // aux motor drive
   // ----------------------------------------------------------------
   logic [FW-1:0] hyst;
   logic [FW:0]   freq_plus_hyst;
   logic          aux_allowed, lvl_on, lvl_off, win_on;
   pmx_aux_t      aux_st, next_aux_st;
   // zero width falls back to the general detect hysteresis
   assign hyst = (aux_motor_hysteresis_width == '0) ?
                 freq_detect_hysteresis : aux_motor_hysteresis_width;
   assign freq_plus_hyst = {1'b0, out_freq} + {1'b0, hyst};
   assign aux_allowed = main_loop_en &&
                        pump_mode_select != `PMX_PM_OFF &&
                        !motors_decreasing;
   assign lvl_on  = all_motors_run && aux_motor_on_level != '0 &&
                    out_freq >= aux_motor_on_level;
   assign lvl_off = freq_plus_hyst < {1'b0, aux_motor_on_level};
   // floating modes FLT2 and FLT12 judge pressure only inside the free-run window
   assign win_on  = win_act &&
                    pressure_pv < aux_motor_pressure_level;

   always_comb begin
      next_aux_st = aux_st;
      if (!aux_allowed) begin
         next_aux_st = PMX_AUX_OFF;
      end else if (is_floating(pump_mode_select)) begin
         next_aux_st = win_on ? PMX_AUX_ON : PMX_AUX_OFF;
      end else begin
         case (aux_st)
            PMX_AUX_OFF: begin
               if (lvl_on) next_aux_st = PMX_AUX_ON;
            end
            PMX_AUX_ON: begin
               if (lvl_off) next_aux_st = PMX_AUX_OFF;
            end
            default: next_aux_st = PMX_AUX_OFF;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_st          <= PMX_AUX_OFF;
         aux_motor_drive <= 1'b0;
      end else begin
         aux_st          <= next_aux_st;
         aux_motor_drive <= next_aux_st == PMX_AUX_ON;
      end
   end

   // ----------------------------------------------------------------
   // motor run-time counters
   // ----------------------------------------------------------------
   logic       inv_ok, mode_fix, mode_flt, mode_lnk;
   logic [4:0] rt_run;
   logic [15:0] rt_val [5];
   assign inv_ok   = gate_on && !dew_prevent;
   assign mode_fix = pump_mode_select == `PMX_PM_FIX1 ||
                     pump_mode_select == `PMX_PM_FIX11;
   assign mode_flt = pump_mode_select == `PMX_PM_FLT2 ||
                     pump_mode_select == `PMX_PM_FLT3 ||
                     pump_mode_select == `PMX_PM_FLT12 ||
                     pump_mode_select == `PMX_PM_FLT13;
   assign mode_lnk = pump_mode_select == `PMX_PM_LNK52 ||
                     pump_mode_select == `PMX_PM_LNK54;
   // counter 0 is the inverter motor or the master unit
   assign rt_run[0] = (mode_fix || mode_lnk) && inv_ok;
   assign rt_run[4] = mode_fix && mains_run[3];

   generate
      for (genvar i = 0; i < 5; i++) begin : g_rt
         pmx_cnt_if #(.W(16)) rif ();
         if (i >= 1 && i <= 3) begin : g_mid
            // mains time counts even when the inverter gate is off
            assign rt_run[i] = (mode_fix && mains_run[i-1]) ||
                               (mode_flt && ((inv_drive[i-1] && inv_ok) ||
                                mains_run[i-1])) ||
                               (mode_lnk && slave_run[i-1]);
         end
         assign rif.run    = rt_run[i];
         assign rif.ld = wr_en && hit_runt && runt_idx == 3'(i);
         assign rif.ld_val = pwdata[15:0];
         assign rif.clr    = 1'b0;
         assign rif.snap   = 1'b0;
         assign rt_val[i]  = rif.val;
         pmx_counter #(.W(16), .SAT(0), .PRE(HOUR_CYC)) u_rt (
            .pclk    (pclk),
            .presetn (presetn),
            .p       (rif)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // relay on-event counters
   // ----------------------------------------------------------------
   logic [7:0]    relay_q, relay_rise;
   logic [RW-1:0] rl_val [8];
   logic [RW-1:0] grp_val [4];
   logic [3:0]    grp_clr;
   logic [1:0]    rl_grp [8];
   assign relay_rise = relay_out & ~relay_q;
   // outputs 0-2 are transistor outs, 3 and 4 single relays, 5-7 option
   assign rl_grp = '{2'd0, 2'd0, 2'd0, 2'd1, 2'd2, 2'd3, 2'd3, 2'd3};
   assign grp_clr = {4{wr_en && hit_relay}} & (4'b0001 << relay_idx);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) relay_q <= '0;
      else          relay_q <= relay_out;
   end

   generate
      for (genvar j = 0; j < 8; j++) begin : g_rl
         pmx_cnt_if #(.W(RW)) cif ();
         assign cif.run    = relay_rise[j] &&
                             is_cascade(pump_mode_select);
         assign cif.ld     = 1'b0;
         assign cif.ld_val = '0;
         assign cif.clr    = grp_clr[rl_grp[j]];
         assign cif.snap   = power_down;
         assign rl_val[j]  = cif.val;
         pmx_counter #(.W(RW), .SAT(1), .MAX(`PMX_RELAY_MAX), .PRE(1))
         u_rl (
            .pclk    (pclk),
            .presetn (presetn),
            .p       (cif)
         );
      end
   endgenerate

   // grouped outputs show the worst relay, not the total wear
   assign grp_val[0] = max3(rl_val[0], rl_val[1], rl_val[2]);
   assign grp_val[1] = rl_val[3];
   assign grp_val[2] = rl_val[4];
   assign grp_val[3] = max3(rl_val[5], rl_val[6], rl_val[7]);

   // ----------------------------------------------------------------
   // external loop enable
   // ----------------------------------------------------------------
   pmx_loop_t lp;
   logic      next_run, next_hold;
   assign lp = loop_decode(ext_loop1_mode_select);
   // the loop-on input is only meaningful once software routes it here
   assign next_run = lp.en && (!lp.run_ilk || inv_running) &&
                     (!lp.cmd_ilk || ext_loop1_on_cmd);
   // stop decel only; a setpoint-driven decel keeps integrating
   assign next_hold = lp.run_ilk && decelerating && !run_cmd;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_loop_run     <= 1'b0;
         ext_loop_inverse <= 1'b0;
         integral_hold    <= 1'b0;
         loop_err_out     <= '0;
      end else begin
         ext_loop_run     <= next_run;
         ext_loop_inverse <= lp.inv;
         integral_hold    <= next_hold;
         loop_err_out     <= lp.inv ? -loop_err : loop_err;
      end
   end

   // ----------------------------------------------------------------
   // apb read and answer
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        rd_hit;
   assign rd_hit = hit_ctrl || hit_auxfrq || hit_auxcfg || hit_timers ||
                   hit_status || hit_runt || hit_relay;
   // relay counts read as raw events; keypad shows 1.000 for 1000
   assign rd_mux =
      hit_ctrl   ? ctrl :
      hit_auxfrq ? auxfrq :
      hit_auxcfg ? auxcfg :
      hit_timers ? timers :
      hit_status ? {27'h0, win_act, integral_hold, ext_loop_inverse,
                    ext_loop_run, aux_motor_drive} :
      hit_runt   ? {16'h0, rt_val[runt_idx]} :
      hit_relay  ? {{(32-RW){1'b0}}, grp_val[relay_idx]} :
      32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= acc;
         pslverr <= acc && !(rd_hit && !(pwrite && hit_status));
         prdata  <= (acc && !pwrite) ? rd_mux : '0;
      end
   end
endmodule : pmx_top

// File: test/pmx_properties.sv
`timescale 1ns/1ps
module pmx_properties (
   input wire logic               pclk,              // clock
   input wire logic               presetn,           // reset
   input wire logic               psel,              // select
   input wire logic               penable,           // enable
   input wire logic               pready,            // ready
   input wire logic               pslverr,           // error
   input wire logic               motors_decreasing, // removal
   input wire logic               aux_motor_drive,   // aux out
   input wire logic               ext_loop_inverse,  // inverse
   input wire logic               integral_hold,     // hold
   input wire logic               run_cmd,           // run
   input wire logic               decelerating,      // slowing
   input wire logic signed [15:0] loop_err,          // err in
   input wire logic signed [15:0] loop_err_out       // err out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // outputs sit at zero just after reset, so history checks wait
   logic [1:0] up;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   a_ready_pulse: assert property (
      pready |=> !pready) else $error("pready held");
   a_access_answer: assert property (
      psel && penable && !pready |=> pready) else $error("no pready");
   a_ready_in_access: assert property (
      pready |-> psel && penable) else $error("stray pready");
   a_err_with_ready: assert property (
      pslverr |-> pready) else $error("pslverr alone");
   a_aux_decrease: assert property (
      motors_decreasing |=> !aux_motor_drive) else $error("aux on");
   a_err_normal: assert property (
      up == 2'h3 && !ext_loop_inverse |-> loop_err_out == $past(loop_err))
      else $error("error changed");
   a_err_negate: assert property (
      up == 2'h3 && ext_loop_inverse |-> loop_err_out == -$past(loop_err))
      else $error("error not negated");
   a_hold_cause: assert property (
      up == 2'h3 && integral_hold |-> $past(decelerating) && !$past(run_cmd))
      else $error("hold without stop");
endmodule : pmx_properties
bind pmx_top pmx_properties u_prop (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .motors_decreasing, .aux_motor_drive,
   .ext_loop_inverse, .integral_hold, .run_cmd, .decelerating,
   .loop_err, .loop_err_out);

// File: test/pmx_plant.sv
`timescale 1ns/1ps
module pmx_plant (
   input  wire logic       pclk,     // clock
   input  wire logic       presetn,  // reset
   input  wire logic [7:0] fire,     // outputs to cycle
   output logic      [7:0] relay_out // contact states
);
   // contacts toggle: one on-event per two cycles while fired
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) relay_out <= 8'h00;
      else relay_out <= fire & ~relay_out;
endmodule : pmx_plant

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, es;
   logic        all_motors_run, add_motor_req, motors_decreasing, gate_on;
   logic        dew_prevent, power_down, inv_running, ext_loop1_on_cmd;
   logic        run_cmd, decelerating, aux_motor_drive, ext_loop_run;
   logic        ext_loop_inverse, integral_hold;
   logic [11:0] paddr, out_freq, pressure_pv;
   logic [31:0] pwdata, prdata, rd, r, seed = 32'h18;
   logic [15:0] v;
   logic [7:0]  fire, relay_out;
   logic [3:0]  mains_run;
   logic [2:0]  inv_drive, slave_run;
   logic signed [15:0] loop_err, loop_err_out;
   int          n, n_mismatch = 0, comparisons = 0, ge[4];
   logic [7:0]  md[9] = '{0, 1, 2, 11, 12, 21, 22, 31, 32};
   logic [11:0] fq[7] = '{499, 500, 480, 479, 500, 470, 469};
   logic        ex[7] = '{0, 1, 1, 0, 1, 1, 0};
   pmx_top #(.HOUR_CYC(20), .TENTH_CYC(4)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .out_freq, .pressure_pv, .all_motors_run, .add_motor_req,
      .motors_decreasing, .gate_on, .dew_prevent, .mains_run, .inv_drive,
      .slave_run, .relay_out, .power_down, .inv_running, .ext_loop1_on_cmd,
      .run_cmd, .decelerating, .loop_err, .aux_motor_drive, .ext_loop_run,
      .ext_loop_inverse, .integral_hold, .loop_err_out);
   pmx_plant u_plant (.pclk, .presetn, .fire, .relay_out);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // background traffic keeps the loop error and hold inputs moving
   always @(posedge pclk) begin
      r = rnd();
      {loop_err, run_cmd, decelerating} <= r[17:0];
      {pressure_pv, mains_run, inv_drive, slave_run} <= r[31:10];
   end
   // apb transfer: hold the request until pready, then let an edge pass
   task automatic xf(input logic [11:0] a, input logic w, logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      es = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xf
   // expected loop outputs {run, inverse} from mode and the two gates
   function automatic logic [1:0] lexp(input logic [7:0] m, logic u, c);
      logic e;
      e = m inside {1, 2} || (m inside {11, 12} && u) ||
          (m inside {21, 22} && c) || (m inside {31, 32} && u && c);
      return {e, m inside {2, 12, 22, 32}};
   endfunction : lexp
   task automatic ax(input logic [11:0] f, input logic e);
      out_freq <= f;
      repeat (2) @(posedge pclk);
      chk("aux", e, aux_motor_drive);
   endtask : ax
   task automatic rl();
      for (int g = 0; g < 4; g++) begin
         xf(12'(40 + 4 * g), 1'b0, 32'h0);
         chk("relay", ge[g], rd);
      end
   endtask : rl
   task automatic chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s: expected %h, seen %h", s, e, g);
      end
   endtask : chk
   task automatic pulse(input logic [7:0] m, input int c);
      fire <= m;
      repeat (2 * c) @(posedge pclk);
      fire <= 8'h00;
      repeat (4) @(posedge pclk);
   endtask : pulse
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      presetn <= 1'b0;
      {psel, penable, pwrite, all_motors_run, add_motor_req, gate_on} <= '0;
      {motors_decreasing, dew_prevent, power_down, inv_running} <= '0;
      {ext_loop1_on_cmd, paddr, pwdata, out_freq, fire} <= '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xf(12'h000, 1'b0, 32'h0);
      chk("ctrl", 32'h0001_0000, rd);
      // pump mode 0: loads stick and no relay is counted
      for (n = 0; n < 5; n++) begin
         v = 16'(rnd());
         xf(12'(20 + 4 * n), 1'b1, {16'h0, v});
         xf(12'(20 + 4 * n), 1'b0, 32'h0);
         chk("runtime", {16'h0, v}, rd);
      end
      pulse(8'hff, 3);
      ge = '{0, 0, 0, 0};
      rl();
      $display("test load done");
      for (int i = 0; i < 9; i++) begin
         xf(12'h000, 1'b1, {16'h0001, md[i], 8'h00});
         for (n = 0; n < 4; n++) begin
            {inv_running, ext_loop1_on_cmd} <= 2'(n);
            repeat (2) @(posedge pclk);
            chk("loop", lexp(md[i], n[1], n[0]),
                {ext_loop_run, ext_loop_inverse});
         end
      end
      $display("test loop done");
      xf(12'h000, 1'b1, 32'h0001_0001);
      xf(12'h004, 1'b1, 32'h0014_01f4);
      xf(12'h008, 1'b1, 32'h0000_001e);
      all_motors_run <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (i == 4) xf(12'h004, 1'b1, 32'h0000_01f4);
         ax(fq[i], ex[i]);
      end
      ax(12'd500, 1'b1);
      motors_decreasing <= 1'b1;
      ax(12'd500, 1'b0);
      motors_decreasing <= 1'b0;
      ax(12'd500, 1'b1);
      xf(12'h000, 1'b1, 32'h0000_0001);
      chk("aux", 1'b0, aux_motor_drive);
      $display("test aux done");
      // 60 gated cycles are ignored, 60 counted ones wrap past the top
      xf(12'h014, 1'b1, 32'h0000_fffe);
      {gate_on, dew_prevent} <= 2'b11;
      repeat (60) @(posedge pclk);
      dew_prevent <= 1'b0;
      repeat (60) @(posedge pclk);
      gate_on <= 1'b0;
      xf(12'h014, 1'b0, 32'h0);
      chk("runtime", 32'h0000_0001, rd);
      pulse(8'h01, 5);
      pulse(8'h02, 7);
      pulse(8'h08, 20);
      pulse(8'h30, 2);
      ge = '{7, 20, 2, 2};
      rl();
      power_down <= 1'b1;
      @(posedge pclk);
      power_down <= 1'b0;
      ge = '{0, 16, 0, 0};
      rl();
      xf(12'h02c, 1'b1, 32'h0);
      ge = '{0, 0, 0, 0};
      rl();
      $display("test relay done");
      xf(12'h000, 1'b1, 32'h0001_0002);
      xf(12'h00c, 1'b1, 32'h0001_0002);
      add_motor_req <= 1'b1;
      @(posedge pclk);
      add_motor_req <= 1'b0;
      xf(12'h010, 1'b0, 32'h0);
      chk("window", 1'b1, rd[4]);
      repeat (100) @(posedge pclk);
      xf(12'h010, 1'b0, 32'h0);
      chk("window", 1'b0, rd[4]);
      chk("aux", 1'b0, aux_motor_drive);
      xf(12'h010, 1'b1, 32'h0);
      chk("error", 1'b1, es);
      $display("test float done");
      end_sim();
   end
   // the tests need about 600 cycles
   initial begin
      #200000;
      n_mismatch++;
      end_sim();
   end
endmodule : tb
